//--- pkg/mmec_defs.svh
// Constants of the monitor-mode entry control block: offsets, fields, resets, times.
// Assumes a single 100 MHz clock and an AXI4-Lite register bus with 32-bit data.
`ifndef MMEC_DEFS_SVH
`define MMEC_DEFS_SVH

// -----------------------------------------------------------------------------
// Register map
// -----------------------------------------------------------------------------
`define MMEC_ADDR_W 4
`define MMEC_OFS_CONTROL 4'h0
`define MMEC_OFS_STATUS 4'h4
`define MMEC_CTRL_W 4
`define MMEC_CTRL_RESET 4'h4
`define MMEC_RESP_OKAY 2'b00
`define MMEC_RESP_SLVERR 2'b10

// -----------------------------------------------------------------------------
// Reset direction select codes
// -----------------------------------------------------------------------------
`define MMEC_DIR_NONE 2'h0
`define MMEC_DIR_FROM_TARGET 2'h1
`define MMEC_DIR_TO_TARGET 2'h2

// -----------------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------------
`define MMEC_CLK_PERIOD_NS 10
`define MMEC_POWER_SETTLE_NS 10000
`define MMEC_STRAP_SETUP_NS 1000
`define MMEC_LOCKOUT_HOLD_NS 1000
`define MMEC_CYCLES(ns) (((ns) + `MMEC_CLK_PERIOD_NS - 1) / `MMEC_CLK_PERIOD_NS)
`define MMEC_TIMER_W 16
// Phase step for 4.9152 MHz from 100 MHz: 2^32 * 2 * 4.9152 / 100, toggling each wrap.
`define MMEC_OSC_STEP 32'h192a7371
`define MMEC_OSC_W 32

`endif

//--- pkg/mmec_pkg.sv
// Types of the monitor-mode entry control block.
// Assumes mmec_defs.svh is compiled alongside for the constants.
package mmec_pkg;

    // Sequencer states, one-hot.
    typedef enum logic [4:0] {
        MMEC_OFF     = 5'b00001,
        MMEC_POWER   = 5'b00010,
        MMEC_STRAP   = 5'b00100,
        MMEC_RELEASE = 5'b01000,
        MMEC_RUN     = 5'b10000
    } mmec_state_e;

    // Software control fields.
    typedef struct packed {
        logic regulatorForceSelect;
        logic clockSourceSelect;
        logic [1:0] resetDirectionSelect;
    } mmec_ctrl_s;

    // Pin drive bundle towards the controller.
    typedef struct packed {
        logic controllerReset_b;
        logic testVoltageLevel;
        logic irqLevel;
        logic hostSerialOut;
        logic hostSerialOe;
        logic [2:0] strapOut;
        logic [2:0] strapOe;
        logic strapConnect;
    } mmec_pins_s;

endpackage

//--- rtl/mmec_osc_gen.sv
// Board oscillator for the controller, built as a phase accumulator.
// Assumes one free-running clock; the output toggles on accumulator wrap.
`include "mmec_defs.svh"
module mmec_osc_gen #(
    parameter logic [`MMEC_OSC_W-1:0] STEP = `MMEC_OSC_STEP
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic enable,
    output logic oscOut
);

    logic [`MMEC_OSC_W-1:0] phase_q, phase_d; // Phase accumulator.
    logic osc_q, osc_d; // Output level.
    logic [`MMEC_OSC_W:0] sum; // Sum with carry.

    // Advance phase and toggle on wrap; stopped when gated off.
    always_comb begin
        sum = {1'b0, phase_q} + {1'b0, STEP};
        phase_d = phase_q;
        osc_d = osc_q;
        if (enable) begin
            phase_d = sum[`MMEC_OSC_W-1:0];
            osc_d = osc_q ^ sum[`MMEC_OSC_W];
        end else begin
            osc_d = 1'b0; // No clock reaches the controller.
        end
    end

    // Register the accumulator.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_q <= '0;
            osc_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            osc_q <= osc_d;
        end
    end

    assign oscOut = osc_q;

endmodule

//--- rtl/mmec_top.sv
// Monitor-mode entry control: power, clock, reset, strapping and lockout.
// Assumes an AXI4-Lite master, synchronous pin inputs and a 100 MHz clock.
`include "mmec_defs.svh"
module mmec_top #(
    parameter int POWER_SETTLE_CYC = `MMEC_CYCLES(`MMEC_POWER_SETTLE_NS),
    parameter int STRAP_SETUP_CYC = `MMEC_CYCLES(`MMEC_STRAP_SETUP_NS),
    parameter int LOCKOUT_HOLD_CYC = `MMEC_CYCLES(`MMEC_LOCKOUT_HOLD_NS)
) (
    input wire logic clk,
    input wire logic rst_b,
    // AXI4-Lite slave.
    input wire logic [`MMEC_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [`MMEC_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Host side.
    input wire logic hostHandshake,
    input wire logic hostTxData,
    output logic hostRxData,
    // Controller side.
    output logic controllerPowerEnable,
    output logic testVoltageEnable,
    output logic controllerClock,
    output logic controllerReset_b,
    output logic testVoltageLevel,
    output logic irqLevel,
    input wire logic hostSerialPinIn,
    output logic hostSerialPinOut,
    output logic hostSerialPinOe,
    output logic [2:0] strapPinOut,
    output logic [2:0] strapPinOe,
    output logic strapConnect,
    // Target connector side.
    input wire logic targetInterruptRequest_n,
    input wire logic targetResetIn_b,
    output logic targetResetOut_b,
    output logic targetResetOutOe
);

    // -------------------------------------------------------------------------
    // Register bus
    // -------------------------------------------------------------------------

    mmec_pkg::mmec_ctrl_s ctrl_q, ctrl_d; // Software control fields.
    logic awHeld_q, awHeld_d; // Write address captured.
    logic wHeld_q, wHeld_d; // Write data captured.
    logic [`MMEC_ADDR_W-1:0] awAddr_q, awAddr_d; // Captured write address.
    logic [31:0] wData_q, wData_d; // Captured write data.
    logic [3:0] wStrb_q, wStrb_d; // Captured strobes.
    logic bValid_q, bValid_d; // Write response pending.
    logic [1:0] bResp_q, bResp_d; // Write response code.
    logic rValid_q, rValid_d; // Read response pending.
    logic [1:0] rResp_q, rResp_d; // Read response code.
    logic [31:0] rData_q, rData_d; // Read data.
    logic [31:0] statusWord; // Live status image.
    mmec_pkg::mmec_state_e state_q, state_d; // Sequencer state.

    // Decodes a word address; used by the write path only, the read path decodes on its own.
    function automatic logic isMapped(input logic [`MMEC_ADDR_W-1:0] a);
        if (a == `MMEC_OFS_CONTROL) begin
            return 1'b1;
        end else if (a == `MMEC_OFS_STATUS) begin
            return 1'b1;
        end else begin
            return 1'b0;
        end
    endfunction

    // Each channel is taken on its own; a new write waits for the response.
    assign awready = !awHeld_q && !bValid_q;
    assign wready = !wHeld_q && !bValid_q;
    assign arready = !rValid_q;
    assign bvalid = bValid_q;
    assign bresp = bResp_q;
    assign rvalid = rValid_q;
    assign rresp = rResp_q;
    assign rdata = rData_q;

    // Status shows the sequencer, its reset and strap pins, and the supply enables.
    assign statusWord = {20'h00000, controllerReset_b, strapConnect, testVoltageEnable,
                         controllerPowerEnable, 3'h0, state_q};

    // Next values of the bus slave and the control register.
    always_comb begin
        ctrl_d = ctrl_q;
        awHeld_d = awHeld_q;
        wHeld_d = wHeld_q;
        awAddr_d = awAddr_q;
        wData_d = wData_q;
        wStrb_d = wStrb_q;
        bValid_d = bValid_q;
        bResp_d = bResp_q;
        rValid_d = rValid_q;
        rResp_d = rResp_q;
        rData_d = rData_q;
        // Capture the write address.
        if (awvalid && awready) begin
            awHeld_d = 1'b1;
            awAddr_d = awaddr;
        end
        // Capture the write data.
        if (wvalid && wready) begin
            wHeld_d = 1'b1;
            wData_d = wdata;
            wStrb_d = wstrb;
        end
        // Perform the write once both halves are held.
        if (awHeld_q && wHeld_q) begin
            awHeld_d = 1'b0;
            wHeld_d = 1'b0;
            bValid_d = 1'b1;
            if (!isMapped(awAddr_q)) begin
                bResp_d = `MMEC_RESP_SLVERR;
            end else begin
                bResp_d = `MMEC_RESP_OKAY;
                if (awAddr_q == `MMEC_OFS_CONTROL && wStrb_q[0]) begin
                    ctrl_d = wData_q[`MMEC_CTRL_W-1:0];
                end
            end
        end
        // Retire the write response.
        if (bValid_q && bready) begin
            bValid_d = 1'b0;
        end
        // Answer a read one cycle after it is taken.
        if (arvalid && arready) begin
            rValid_d = 1'b1;
            if (araddr == `MMEC_OFS_CONTROL) begin
                rData_d = {28'h0000000, ctrl_q};
                rResp_d = `MMEC_RESP_OKAY;
            end else if (araddr == `MMEC_OFS_STATUS) begin
                rData_d = statusWord;
                rResp_d = `MMEC_RESP_OKAY;
            end else begin
                rData_d = 32'h00000000;
                rResp_d = `MMEC_RESP_SLVERR;
            end
        end else if (rValid_q && rready) begin
            rValid_d = 1'b0;
        end
    end

    // Register the bus slave.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= `MMEC_CTRL_RESET;
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= '0;
            wData_q <= 32'h00000000;
            wStrb_q <= 4'h0;
            bValid_q <= 1'b0;
            bResp_q <= `MMEC_RESP_OKAY;
            rValid_q <= 1'b0;
            rResp_q <= `MMEC_RESP_OKAY;
            rData_q <= 32'h00000000;
        end else begin
            ctrl_q <= ctrl_d;
            awHeld_q <= awHeld_d;
            wHeld_q <= wHeld_d;
            awAddr_q <= awAddr_d;
            wData_q <= wData_d;
            wStrb_q <= wStrb_d;
            bValid_q <= bValid_d;
            bResp_q <= bResp_d;
            rValid_q <= rValid_d;
            rResp_q <= rResp_d;
            rData_q <= rData_d;
        end
    end

    // -------------------------------------------------------------------------
    // Supply, regulator and clock
    // -------------------------------------------------------------------------

    logic resetRequest_b; // Target reset request after direction selection.
    logic oscOut; // Board oscillator.

    // The handshake line alone switches the controller supply.
    assign controllerPowerEnable = hostHandshake;
    // Regulator forced on, or following the handshake line.
    assign testVoltageEnable = ctrl_q.regulatorForceSelect | hostHandshake;
    // The request counts only when the target may reset us; else inactive high.
    assign resetRequest_b = (ctrl_q.resetDirectionSelect == `MMEC_DIR_FROM_TARGET) ?
                            targetResetIn_b : 1'b1;

    // Oscillator at the monitor serial rate, gated by the clock select.
    mmec_osc_gen #(
        .STEP(`MMEC_OSC_STEP)
    ) oscGen (
        .clk(clk),
        .rst_b(rst_b),
        .enable(ctrl_q.clockSourceSelect && hostHandshake),
        .oscOut(oscOut)
    );
    assign controllerClock = oscOut;

    // -------------------------------------------------------------------------
    // Entry sequencer
    // -------------------------------------------------------------------------

    logic [`MMEC_TIMER_W-1:0] timer_q, timer_d; // Phase countdown.
    mmec_pkg::mmec_pins_s pins_q, pins_d; // Registered pin drive.

    // Walks power-up, strapping, release and run.
    always_comb begin
        state_d = state_q;
        timer_d = timer_q;
        if (timer_q != '0) begin
            timer_d = timer_q - 1'b1;
        end
        case (state_q)
            mmec_pkg::MMEC_OFF: begin
                // Wait for the host to apply power.
                if (hostHandshake) begin
                    state_d = mmec_pkg::MMEC_POWER;
                    timer_d = POWER_SETTLE_CYC[`MMEC_TIMER_W-1:0];
                end
            end
            mmec_pkg::MMEC_POWER: begin
                // Power, clock and test voltage must all stand.
                if (timer_q == '0 && ctrl_q.clockSourceSelect && testVoltageEnable) begin
                    state_d = mmec_pkg::MMEC_STRAP;
                    timer_d = STRAP_SETUP_CYC[`MMEC_TIMER_W-1:0];
                end
            end
            mmec_pkg::MMEC_STRAP: begin
                // Straps settle before reset rises; a target request holds here.
                if (timer_q == '0 && resetRequest_b) begin
                    state_d = mmec_pkg::MMEC_RELEASE;
                    timer_d = LOCKOUT_HOLD_CYC[`MMEC_TIMER_W-1:0];
                end
            end
            mmec_pkg::MMEC_RELEASE: begin
                // Reset is high; lockout stays a while longer.
                if (!resetRequest_b) begin
                    state_d = mmec_pkg::MMEC_STRAP;
                    timer_d = STRAP_SETUP_CYC[`MMEC_TIMER_W-1:0];
                end else if (timer_q == '0) begin
                    state_d = mmec_pkg::MMEC_RUN;
                end
            end
            mmec_pkg::MMEC_RUN: begin
                // A target reset request restarts monitor entry.
                if (!resetRequest_b) begin
                    state_d = mmec_pkg::MMEC_STRAP;
                    timer_d = STRAP_SETUP_CYC[`MMEC_TIMER_W-1:0];
                end
            end
            default: begin
                state_d = mmec_pkg::MMEC_OFF;
            end
        endcase
        // Losing power always returns to reset with lockout.
        if (!hostHandshake) begin
            state_d = mmec_pkg::MMEC_OFF;
            timer_d = '0;
        end
    end

    // Pin drive for the next state.
    always_comb begin
        pins_d.controllerReset_b = (state_d == mmec_pkg::MMEC_RELEASE) ||
                                   (state_d == mmec_pkg::MMEC_RUN);
        // Lockout holds until the run state; reset low forces it.
        pins_d.testVoltageLevel = (state_d != mmec_pkg::MMEC_RUN);
        pins_d.irqLevel = (state_d == mmec_pkg::MMEC_RUN) ? targetInterruptRequest_n : 1'b1;
        // Host serial pin idles high in reset, else follows host data.
        pins_d.hostSerialOut = !pins_d.controllerReset_b;
        pins_d.hostSerialOe = !pins_d.controllerReset_b || !hostTxData;
        // Straps first,second,third = 1,0,0 driven until reset rises.
        pins_d.strapOut = 3'b001;
        pins_d.strapOe = (state_d == mmec_pkg::MMEC_RUN ||
                          state_d == mmec_pkg::MMEC_RELEASE) ? 3'b000 : 3'b111;
        // Target side joins in the same cycle as reset rises.
        pins_d.strapConnect = (state_d == mmec_pkg::MMEC_RUN) ||
                              (state_d == mmec_pkg::MMEC_RELEASE);
    end

    // Register sequencer and pins.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= mmec_pkg::MMEC_OFF;
            timer_q <= '0;
            pins_q <= {1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 3'b001, 3'b111, 1'b0};
        end else begin
            state_q <= state_d;
            timer_q <= timer_d;
            pins_q <= pins_d;
        end
    end

    assign controllerReset_b = pins_q.controllerReset_b;
    assign testVoltageLevel = pins_q.testVoltageLevel;
    assign irqLevel = pins_q.irqLevel;
    assign hostSerialPinOut = pins_q.hostSerialOut;
    assign hostSerialPinOe = pins_q.hostSerialOe;
    assign strapPinOut = pins_q.strapOut;
    assign strapPinOe = pins_q.strapOe;
    assign strapConnect = pins_q.strapConnect;
    // The serial pin reaches only the host, never a target pin.
    assign hostRxData = hostSerialPinIn;
    // Reset out to target only in the board-drives direction; one-way.
    assign targetResetOut_b = controllerReset_b;
    assign targetResetOutOe = (ctrl_q.resetDirectionSelect == `MMEC_DIR_TO_TARGET);

endmodule

//--- verification/mmec_host_model.sv
// Host serial port model: power handshake and serial data.
// Assumes the bench raises powerReq to ask for a monitor session.
module mmec_host_model #(
    parameter int PULSES = 2,
    parameter logic [7:0] SECURITY_CODE = 8'h5a // Arbitrary value.
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic powerReq,
    output logic hostHandshake,
    output logic hostTxData
);
    timeunit 1ns;
    timeprecision 1ps;
    int pulseCnt; // Power pulses given so far.
    int phase; // Step within one pulse.
    int bitIdx; // Next code bit to send.
    // Pulse power a few times, then hold it and send the code.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b || !powerReq) begin
            hostHandshake <= 1'b0;
            hostTxData <= 1'b1;
            pulseCnt <= 0;
            phase <= 0;
            bitIdx <= 0;
        end else if (pulseCnt < PULSES) begin
            phase <= (phase + 1) % 6;
            hostHandshake <= (phase < 3);
            if (phase == 5) begin
                pulseCnt <= pulseCnt + 1;
            end
        end else begin
            hostHandshake <= 1'b1;
            hostTxData <= (bitIdx < 8) ? SECURITY_CODE[bitIdx] : 1'b1;
            if (bitIdx < 9) begin
                bitIdx <= bitIdx + 1;
            end
        end
    end
endmodule

//--- verification/mmec_top_asserts.sv
// Checker for the monitor-mode entry control top; sees only its ports.
// Assumes one clock domain and the bind at the foot of this file.
`include "mmec_defs.svh"
module mmec_top_asserts (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic hostHandshake,
    input wire logic hostTxData,
    input wire logic controllerPowerEnable,
    input wire logic controllerClock,
    input wire logic controllerReset_b,
    input wire logic testVoltageLevel,
    input wire logic irqLevel,
    input wire logic hostSerialPinOut,
    input wire logic hostSerialPinOe,
    input wire logic [2:0] strapPinOut,
    input wire logic [2:0] strapPinOe,
    input wire logic strapConnect,
    input wire logic targetInterruptRequest_n,
    input wire logic targetResetOut_b,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // The controller reset is let go at this step.
    sequence s_rise;
        $rose(controllerReset_b);
    endsequence
    // Power is held off across two samples.
    sequence s_off2;
        !hostHandshake ##1 !hostHandshake;
    endsequence
    a_strap_values: assert property (s_rise |-> $past(strapPinOut) == 3'b001 &&
        $past(strapPinOe) == 3'b111 && $past(hostSerialPinOut) && $past(hostSerialPinOe))
        else $error("strap values wrong at reset release");
    a_lockout_reset: assert property (!controllerReset_b |-> testVoltageLevel && irqLevel)
        else $error("lockout missing during reset");
    a_lockout_hold: assert property (s_rise |-> testVoltageLevel [*2])
        else $error("lockout dropped too early");
    a_irq_pass: assert property (!testVoltageLevel |-> irqLevel == $past(targetInterruptRequest_n))
        else $error("interrupt request not passed");
    a_strap_isolate: assert property (!controllerReset_b |-> !strapConnect && strapPinOe == 3'b111)
        else $error("strap pins joined during reset");
    a_serial_host: assert property (controllerReset_b && $past(controllerReset_b) |->
        !hostSerialPinOut && hostSerialPinOe == !$past(hostTxData))
        else $error("host serial pin misdriven");
    a_power_follows: assert property (controllerPowerEnable == hostHandshake)
        else $error("power does not follow handshake");
    a_power_drop: assert property (!hostHandshake |=> !controllerReset_b && testVoltageLevel)
        else $error("power loss did not reset");
    a_clock_stops: assert property (s_off2 |-> !controllerClock)
        else $error("clock runs without power");
    a_release_order: assert property (s_rise |-> $past(hostHandshake, 5))
        else $error("reset released too soon");
    a_reset_oneway: assert property (targetResetOut_b == controllerReset_b)
        else $error("target reset output wrong");
    a_resp_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response not held");
endmodule
bind mmec_top mmec_top_asserts u_asserts (.clk, .rst_b, .hostHandshake, .hostTxData,
    .controllerPowerEnable, .controllerClock, .controllerReset_b, .testVoltageLevel,
    .irqLevel, .hostSerialPinOut, .hostSerialPinOe, .strapPinOut, .strapPinOe, .strapConnect,
    .targetInterruptRequest_n, .targetResetOut_b, .bvalid, .bready, .bresp);

//--- verification/test_monitor_mode_entry_control.sv
// Self-checking bench for the monitor-mode entry control top.
// Assumes the host model and the bound checker are compiled alongside.
`include "mmec_defs.svh"
module test_monitor_mode_entry_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_b, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
    logic arready, rvalid, hostHandshake, hostTxData, hostRxData, hostSerialPinIn;
    logic controllerPowerEnable, testVoltageEnable, controllerClock, controllerReset_b;
    logic testVoltageLevel, irqLevel, hostSerialPinOut, hostSerialPinOe, strapConnect;
    logic targetInterruptRequest_n, targetResetIn_b, targetResetOut_b, targetResetOutOe;
    logic powerReq, v, prev;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic [2:0] strapPinOut, strapPinOe;
    logic [33:0] expQ[$]; // Expected {resp, data} of each bus answer.
    int fails, checks_done, cnt;
    longint expT;
    mmec_top #(.POWER_SETTLE_CYC(4), .STRAP_SETUP_CYC(2), .LOCKOUT_HOLD_CYC(2)) uut (.clk,
        .rst_b, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
        .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .hostHandshake,
        .hostTxData, .hostRxData, .controllerPowerEnable, .testVoltageEnable, .controllerClock,
        .controllerReset_b, .testVoltageLevel, .irqLevel, .hostSerialPinIn, .hostSerialPinOut,
        .hostSerialPinOe, .strapPinOut, .strapPinOe, .strapConnect, .targetInterruptRequest_n,
        .targetResetIn_b, .targetResetOut_b, .targetResetOutOe);
    mmec_host_model u_host (.clk, .rst_b, .powerReq, .hostHandshake, .hostTxData);
    // The controller drives its serial pin only while its enable is set; released, the line rises to its pull-up.
    assign hostSerialPinIn = hostSerialPinOe ? hostSerialPinOut : 1'b1;
    always #5 clk = ~clk;
    // Compare one value with its expectation and count the result.
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // Print the counts and the verdict, then end the run.
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // A wait that used its whole bound ends the run as a mismatch.
    task automatic bound(input int n);
        if (n >= 300) begin
            fails++;
            stop_test();
        end
    endtask
    // One AXI4-Lite write; address and data offered together.
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        expQ.push_back({r, 32'h0});
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!(bvalid && bready) && n < 300);
        bready <= 1'b0;
        bound(n);
    endtask
    // One AXI4-Lite read.
    task automatic axi_read(input logic [3:0] a, input logic [33:0] e);
        int n;
        n = 0;
        @(posedge clk);
        expQ.push_back(e);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!(rvalid && rready) && n < 300);
        rready <= 1'b0;
        bound(n);
    endtask
    // Wait, bounded, until the controller reset is let go.
    task automatic wait_rise();
        int n;
        n = 0;
        while (controllerReset_b !== 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
        end
        bound(n);
    endtask
    // Each bus answer taken is matched with the oldest expectation.
    always @(posedge clk) begin
        if ((rvalid && rready) || (bvalid && bready)) begin
            if (expQ.size() == 0) begin
                check(34'h1, 34'h0);
            end else begin
                check(rvalid ? {rresp, rdata} : {bresp, 32'h0}, expQ.pop_front());
            end
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {clk, rst_b, awvalid, wvalid, bready, arvalid, rready, powerReq} = '0;
        {awaddr, araddr, wstrb, wdata} = '0;
        targetInterruptRequest_n = 1'b1;
        targetResetIn_b = 1'b1;
        void'($urandom(32'hc8bf3233));
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        axi_read(4'h0, 34'h4);
        axi_read(4'h4, 34'h1);
        axi_write(4'h8, 32'hf, 2'b10);
        axi_read(4'h8, {2'b10, 32'h0});
        axi_write(4'h0, 32'h0, 2'b00);
        powerReq <= 1'b1;
        repeat (40) @(posedge clk);
        axi_read(4'h4, 34'h302);
        check(34'(controllerClock), 34'h0);
        powerReq <= 1'b0;
        axi_write(4'h0, 32'h6, 2'b00);
        powerReq <= 1'b1;
        wait_rise();
        check(34'(targetResetOutOe), 34'h1);
        // The lockout hold runs out before the run state shows in status.
        repeat (2) @(posedge clk);
        axi_read(4'h4, 34'hf10);
        for (int i = 0; i < 8; i++) begin
            v = 1'($urandom);
            targetInterruptRequest_n <= v;
            repeat (2) @(posedge clk);
            check(34'(irqLevel), 34'(v));
            check(34'(hostRxData), 34'(hostTxData));
        end
        expT = (longint'(1000) * longint'(`MMEC_OSC_STEP)) >> 32;
        cnt = 0;
        prev = controllerClock;
        for (int i = 0; i < 1000; i++) begin
            @(posedge clk);
            if (controllerClock !== prev) cnt++;
            prev = controllerClock;
        end
        check(34'(cnt >= expT && cnt <= expT + 1), 34'h1);
        axi_write(4'h0, 32'h5, 2'b00);
        targetResetIn_b <= 1'b0;
        repeat (3) @(posedge clk);
        check(34'(controllerReset_b), 34'h0);
        check(34'(targetResetOutOe), 34'h0);
        check(34'(strapConnect), 34'h0);
        targetResetIn_b <= 1'b1;
        wait_rise();
        powerReq <= 1'b0;
        // One edge for the host to drop power, one for the sequencer, one to settle.
        repeat (3) @(posedge clk);
        check(34'(controllerReset_b), 34'h0);
        axi_read(4'h4, 34'h1);
        axi_write(4'h0, 32'hc, 2'b00);
        check(34'(testVoltageEnable), 34'h1);
        check(34'(controllerPowerEnable), 34'h0);
        axi_read(4'h0, 34'hc);
        repeat (3) @(posedge clk);
        stop_test();
    end
endmodule
